// ===== src/ubu_defines.vh
/*
 Constants for the unconditional branch unit: opcodes, field positions,
 addressing-mode codes and reset values. Assumes plain Verilog-2005 include.
*/
`ifndef UBU_DEFINES_VH
`define UBU_DEFINES_VH

`define UBU_OP_BRANCH      8'h08
`define UBU_OP_JUMP_EXT    8'h84
`define UBU_OP_MSB         31
`define UBU_OP_LSB         24
`define UBU_DISP_MSB       23
`define UBU_DISP_LSB       2
`define UBU_DISP_W         22
`define UBU_REG_MSB        18
`define UBU_REG_LSB        14
`define UBU_MODE_MSB       13
`define UBU_MODE_LSB       10
`define UBU_MODE_ABS       4'h0
`define UBU_MODE_REG_IND   4'h4
`define UBU_MODE_IP_DISP   4'h5
`define UBU_MODE_IDX_DISP  4'h7
`define UBU_MODE_REG_DISP  4'hc
`define UBU_IP_RESET       32'h00000000
`define UBU_ISTR_LEN_SHORT 32'h00000004
`define UBU_ISTR_LEN_LONG  32'h00000008

`endif

// ===== src/ubu_target_adder.v
/*
 Word-granular target adder: adds two 30-bit word addresses and forces the
 two low bits of the result to zero. Assumes purely combinational use.
*/
`timescale 1ns/1ps
module ubu_target_adder
(
	input  wire [29:0] BASE_WORD,
	input  wire [29:0] OFFS_WORD,
	output wire [31:0] TARGET
);
	wire [29:0] sum_word;

	assign sum_word = BASE_WORD + OFFS_WORD;
	assign TARGET = {sum_word, 2'b00};
endmodule

// ===== src/ubu_branch_unit.v
/*
 Execution logic for the short relative branch and the extended jump.
 Assumes decode presents one instruction word with INSTR_VALID, that the
 effective-address generator supplies a finished address for the extended
 form, and that the register file supplies the named register's value.
*/
`timescale 1ns/1ps
`include "ubu_defines.vh"

// Operation
// - Short branch reaches -2^23 to 2^23-4 bytes
// - Extended jump reaches whole 32-bit space
// - Extended target: effective address bits 31:2
// - Extended jump accepts every memory addressing mode
// - Register-indirect mode takes target from register
module ubu_branch_unit
(
	input  wire        CLK,
	input  wire        RST_B,
	input  wire        INSTR_VALID,
	input  wire [31:0] INSTR_WORD,
	input  wire [31:0] INSTR_IP,
	input  wire [31:0] EA_ADDR,
	input  wire        EA_VALID,
	input  wire [31:0] REG_VALUE,
	output reg         BR_TAKEN,
	output reg  [31:0] BR_TARGET,
	output reg         BR_EXTENDED,
	output reg         BR_BAD_MODE
);
	wire [7:0]  opcode;
	wire [3:0]  mode;
	wire [21:0] disp_field;
	wire        disp_sign;
	wire [29:0] disp_word;
	wire [29:0] ip_word;
	wire        is_short;
	wire        is_ext;
	wire        ext_go;
	wire        ext_stall;
	wire [31:0] short_target;
	wire [31:0] ext_target;
	reg  [31:0] ext_addr;
	reg         mode_ok;
	reg         taken_nxt;
	reg  [31:0] target_nxt;
	reg         ext_nxt;
	reg         bad_nxt;

	// Field split of the instruction word
	assign opcode     = INSTR_WORD[`UBU_OP_MSB:`UBU_OP_LSB];
	assign mode       = INSTR_WORD[`UBU_MODE_MSB:`UBU_MODE_LSB];
	assign disp_field = INSTR_WORD[`UBU_DISP_MSB:`UBU_DISP_LSB];
	assign disp_sign  = INSTR_WORD[`UBU_DISP_MSB];
	assign ip_word    = INSTR_IP[31:2];

	assign is_short = INSTR_VALID && (opcode == `UBU_OP_BRANCH);
	assign is_ext   = INSTR_VALID && (opcode == `UBU_OP_JUMP_EXT);

	// Extended form only moves once its address source is usable
	assign ext_go    = is_ext && mode_ok;
	assign ext_stall = is_ext && !mode_ok;

	assign disp_word = {{8{disp_sign}}, disp_field};

	// Word adder keeps the sum aligned; a carry out of bit 31 wraps
	ubu_target_adder u_short_add
	(
		.BASE_WORD (ip_word),
		.OFFS_WORD (disp_word),
		.TARGET    (short_target)
	);

	assign ext_target = {ext_addr[31:2], 2'b00};

	// Address source per addressing mode
	always @*
	begin
		ext_addr = EA_ADDR;
		mode_ok  = EA_VALID;
		case (mode)
			`UBU_MODE_REG_IND:
			begin
				ext_addr = REG_VALUE;
				mode_ok  = 1'b1;
			end
			`UBU_MODE_ABS:
			begin
				ext_addr = EA_ADDR;
				mode_ok  = EA_VALID;
			end
			`UBU_MODE_IP_DISP:
			begin
				ext_addr = EA_ADDR;
				mode_ok  = EA_VALID;
			end
			`UBU_MODE_IDX_DISP:
			begin
				ext_addr = EA_ADDR;
				mode_ok  = EA_VALID;
			end
			`UBU_MODE_REG_DISP:
			begin
				ext_addr = EA_ADDR;
				mode_ok  = EA_VALID;
			end
			default:
			begin
				// Unlisted modes still trust the address generator
				ext_addr = EA_ADDR;
				mode_ok  = EA_VALID;
			end
		endcase
	end

	// Taken pulse; the two forms never share an opcode
	always @*
	begin
		taken_nxt = 1'b0;
		if (is_short)
		begin
			taken_nxt = 1'b1;
		end
		else if (ext_go)
		begin
			taken_nxt = 1'b1;
		end
	end

	always @*
	begin
		ext_nxt = 1'b0;
		if (ext_go)
		begin
			ext_nxt = 1'b1;
		end
	end

	// Missing address holds fetch; no jump to stale data
	always @*
	begin
		bad_nxt = 1'b0;
		if (ext_stall)
		begin
			bad_nxt = 1'b1;
		end
	end

	// Target holds between branches so fetch may sample it late
	always @*
	begin
		target_nxt = BR_TARGET;
		if (is_short)
		begin
			target_nxt = short_target;
		end
		else if (ext_go)
		begin
			target_nxt = ext_target;
		end
	end

	// Each output leaves straight from its own flop
	always @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			BR_TAKEN <= 1'b0;
		end
		else
		begin
			BR_TAKEN <= taken_nxt;
		end
	end

	always @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			BR_EXTENDED <= 1'b0;
		end
		else
		begin
			BR_EXTENDED <= ext_nxt;
		end
	end

	always @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			BR_BAD_MODE <= 1'b0;
		end
		else
		begin
			BR_BAD_MODE <= bad_nxt;
		end
	end

	// Target falls back to the reset IP, not to a branch result
	always @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			BR_TARGET <= `UBU_IP_RESET;
		end
		else
		begin
			BR_TARGET <= target_nxt;
		end
	end
endmodule

// ===== tb/ubu_monitor.sv
/* Assertions on the branch unit ports.
 Assumes a bind from the testbench top. */
`timescale 1ns/1ps
module ubu_monitor
(
	input wire        CLK,
	input wire        RST_B,
	input wire        INSTR_VALID,
	input wire [31:0] INSTR_WORD,
	input wire [31:0] INSTR_IP,
	input wire [31:0] EA_ADDR,
	input wire        EA_VALID,
	input wire [31:0] REG_VALUE,
	input wire        BR_TAKEN,
	input wire [31:0] BR_TARGET,
	input wire        BR_EXTENDED,
	input wire        BR_BAD_MODE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	wire        s = INSTR_VALID && INSTR_WORD[31:24] == 8'h84 - 8'h7c;
	wire        x = INSTR_VALID && INSTR_WORD[31:24] == 8'h84;
	wire        r = INSTR_WORD[13:10] == 4'h4;
	wire [29:0] e = INSTR_IP[31:2] + {{8{INSTR_WORD[23]}}, INSTR_WORD[23:2]};
	sequence ext_hit;
		BR_TAKEN && BR_EXTENDED && !BR_BAD_MODE;
	endsequence
	a_short_target: assert property (s |=> BR_TAKEN && !BR_EXTENDED && BR_TARGET == {$past(e), 2'b00})
		else $error("short target wrong");
	a_ext_addr: assert property (x && !r && EA_VALID |=> ext_hit ##0 BR_TARGET == {$past(EA_ADDR[31:2]), 2'b00})
		else $error("extended target wrong");
	a_ext_reg: assert property (x && r |=> ext_hit ##0 BR_TARGET == {$past(REG_VALUE[31:2]), 2'b00})
		else $error("indirect target wrong");
	a_bad_mode: assert property (x && !r && !EA_VALID |=> BR_BAD_MODE && !BR_TAKEN)
		else $error("missing address not flagged");
	a_low_zero: assert property (BR_TAKEN |-> BR_TARGET[1:0] == 2'b00)
		else $error("low target bits set");
	a_no_spur: assert property (BR_TAKEN |-> $past(s || x && (r || EA_VALID)))
		else $error("branch without request");
	a_target_hold: assert property (!BR_TAKEN |-> $stable(BR_TARGET))
		else $error("target moved without branch");
	a_bad_only: assert property (BR_BAD_MODE |-> $past(x && !r && !EA_VALID))
		else $error("bad mode without request");
endmodule

// ===== tb/testbench.sv
/* Scenario testbench for the branch unit.
 Assumes the design sources and the monitor. */
`timescale 1ns/1ps
module testbench;
	reg        clk = 0, rst_b = 0, iv = 0, ev = 0;
	reg [31:0] iw = 0, ip = 32'h00001000, ea = 0;
	wire       tk, ex, bd;
	wire [31:0] tg;
	integer    failures = 0, n_tests = 0;
	always #5 clk = ~clk;
	ubu_branch_unit uut (.CLK(clk), .RST_B(rst_b), .INSTR_VALID(iv), .INSTR_WORD(iw), .INSTR_IP(ip),
		.EA_ADDR(ea), .EA_VALID(ev), .REG_VALUE(~ea), .BR_TAKEN(tk), .BR_TARGET(tg), .BR_EXTENDED(ex), .BR_BAD_MODE(bd));
	// Register value is the inverse of the address, so a wrong source shows
	// Target is compared every cycle: it must hold when nothing is taken
	task go(input v, input [31:0] w, a, input e, input [2:0] f, input [31:0] t);
	begin
		iw = w;
		ea = a;
		ev = e;
		iv = v;
		@(posedge clk) #1 n_tests = n_tests + 1;
		if ({tk, ex, bd} !== f || tg !== t)
		begin
			failures = failures + 1;
			$display("[ERR] %0t flags %b target %h", $time, {tk, ex, bd}, tg);
		end
	end
	endtask
	task t_short;
	begin
		go(1, 32'h087ffffc, 0, 0, 3'b100, 32'h00800ffc);
		go(1, 32'h08800000, 0, 0, 3'b100, 32'hff801000);
	end
	endtask
	task t_ext;
	begin
		go(1, 32'h84000000, 32'hfffffff3, 1, 3'b110, 32'hfffffff0);
		go(1, 32'h84001400, 32'h00000a07, 1, 3'b110, 32'h00000a04);
		go(1, 32'h84001c00, 32'h80000001, 1, 3'b110, 32'h80000000);
		go(1, 32'h84003000, 32'h00000010, 1, 3'b110, 32'h00000010);
		go(1, 32'h84000400, 32'h1234567b, 1, 3'b110, 32'h12345678);
		go(1, 32'h84001000, 32'hfffffff3, 0, 3'b110, 32'h0000000c);
	end
	endtask
	task t_refuse;
	begin
		go(1, 32'h84001400, 32'h00000a04, 0, 3'b001, 32'h0000000c);
		go(1, 32'h0b000000, 0, 1, 3'b000, 32'h0000000c);
		go(0, 32'h08000004, 0, 0, 3'b000, 32'h0000000c);
	end
	endtask
	// Mid-run reset clears the held target, then a branch works at once
	task t_reset;
	begin
		rst_b = 0;
		#1 n_tests = n_tests + 1;
		if ({tk, ex, bd} !== 3'b000 || tg !== 32'h00000000)
		begin
			failures = failures + 1;
			$display("[ERR] %0t reset flags %b target %h", $time, {tk, ex, bd}, tg);
		end
		@(posedge clk) #1 rst_b = 1;
		go(1, 32'h08000004, 0, 0, 3'b100, 32'h00001004);
		go(0, 32'h08000004, 0, 0, 3'b000, 32'h00001004);
	end
	endtask
	task close_out;
	begin
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		#1 rst_b = 1;
		t_short;
		t_ext;
		t_refuse;
		t_reset;
		@(posedge clk) #1 iv = 0;
		close_out;
	end
	// Whole run is about twenty cycles
	initial
	begin
		#2000 failures = failures + 1;
		close_out;
	end
endmodule
bind ubu_branch_unit ubu_monitor mon
(
	.CLK         (CLK),
	.RST_B       (RST_B),
	.INSTR_VALID (INSTR_VALID),
	.INSTR_WORD  (INSTR_WORD),
	.INSTR_IP    (INSTR_IP),
	.EA_ADDR     (EA_ADDR),
	.EA_VALID    (EA_VALID),
	.REG_VALUE   (REG_VALUE),
	.BR_TAKEN    (BR_TAKEN),
	.BR_TARGET   (BR_TARGET),
	.BR_EXTENDED (BR_EXTENDED),
	.BR_BAD_MODE (BR_BAD_MODE)
);
